// ==== ddr2_seq_pkg.sv ====
// Purpose: shared constants for the DDR2 command sequencing device logic
// Assumes: commands are sampled on rising edges of the link clock
// Notes: latencies and exit delays are counted in link clock cycles
package ddr2_seq_pkg;
	// Command code is {cs_b, ras_b, cas_b, we_b}
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_ACTIVATE = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;
	// Burst sizes in data beats
	localparam logic [3:0] BEATS_BL4 = 4'h4;
	localparam logic [3:0] BEATS_BL8 = 4'h8;
	// Self refresh exit delays in link clocks
	localparam int EXIT_TO_READ_CLKS = 200;
	localparam int EXIT_TO_NONREAD_CLKS = 10;
	// Scheduler depth and field widths
	localparam int MAX_LATENCY = 12;
	localparam int LAT_W = 4;
	localparam int DATA_W = 16;
	localparam int EXIT_W = 8;
	// Pin sampler layout: link clock is the top bit
	localparam int PIN_W = 26;
	localparam int PIN_CK = 25;
	localparam int PIN_CKE = 24;
	localparam int PIN_CMD_LSB = 20;
	localparam int PIN_BA_LSB = 18;
	localparam int PIN_AP = 17;
	localparam int PIN_TERM = 16;
	// Reset image: command pins high (deselected), everything else low
	localparam logic [PIN_W-1:0] PIN_RESET = 26'h0F00000;

	typedef enum logic [1:0] {
		MODE_ACTIVE = 2'b00,
		MODE_SELF_REFRESH = 2'b01,
		MODE_POWER_DOWN = 2'b10
	} mode_t;

	// Beats in one burst for the selected burst length
	function automatic logic [3:0] burst_beats(input logic bl8);
		return bl8 ? BEATS_BL8 : BEATS_BL4;
	endfunction
endpackage

// ==== burst_if.sv ====
`timescale 1ns/10ps
// Purpose: carries link edge ticks, burst commands and beat strobes to a latency pipe
// Assumes: rise and fall never pulse in the same cycle
// Notes: one instance per direction
interface burst_if;
	logic rise;
	logic fall;
	logic cmd;
	logic bl8;
	logic [3:0] latency;
	logic active;
	logic beat;
	logic last;
	logic [2:0] beat_index;

	modport ctrl(output rise, fall, cmd, bl8, latency, input active, beat, last, beat_index);
	modport pipe(input rise, fall, cmd, bl8, latency, output active, beat, last, beat_index);
endinterface

// ==== latency_pipe.sv ====
`timescale 1ns/10ps
// Purpose: delays a burst command by a latency in link clocks and paces its beats
// Assumes: latency is at least 1
// Notes: a new burst may start on the edge right after the previous last beat
module latency_pipe #(
	parameter int MAX_LAT = ddr2_seq_pkg::MAX_LATENCY
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Burst channel
	burst_if.pipe bus
);
	import ddr2_seq_pkg::*;

	logic [MAX_LAT-1:0] sched_reg, sched_next;
	logic [3:0] left_reg, left_next;
	logic [2:0] idx_reg, idx_next;
	logic start;
	logic beat;
	logic last;
	logic [2:0] beat_index;

	// Schedule shifts once per link clock; a burst starts when its mark reaches bit 0
	always_comb begin
		sched_next = sched_reg;
		left_next = left_reg;
		idx_next = idx_reg;
		start = bus.rise && sched_reg[0];
		beat = 1'b0;
		last = 1'b0;
		beat_index = idx_reg;
		if (bus.rise) begin
			sched_next = sched_reg >> 1;
			if (bus.cmd) begin
				sched_next[bus.latency - 4'h1] = 1'b1;
			end
		end
		if (start) begin
			// Start wins over a finishing burst, so back-to-back bursts abut
			beat = 1'b1;
			beat_index = 3'h0;
			idx_next = 3'h1;
			left_next = burst_beats(bus.bl8) - 4'h1;
		end else if ((bus.rise || bus.fall) && left_reg != 4'h0) begin
			beat = 1'b1;
			last = left_reg == 4'h1;
			idx_next = idx_reg + 3'h1;
			left_next = left_reg - 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sched_reg <= '0;
			left_reg <= 4'h0;
			idx_reg <= 3'h0;
		end else begin
			sched_reg <= sched_next;
			left_reg <= left_next;
			idx_reg <= idx_next;
		end
	end

	assign bus.beat = beat;
	assign bus.last = last;
	assign bus.beat_index = beat_index;
	assign bus.active = (left_reg != 4'h0) || (sched_reg != '0);

	sequence s_cmd_taken;
		bus.rise && bus.cmd;
	endsequence

	sequence s_burst_open;
		bus.rise && sched_reg[0];
	endsequence

	a_sched_load: assert property (@(posedge clk) disable iff (!rst_b)
		s_cmd_taken |=> sched_reg[$past(bus.latency) - 4'h1])
		else $error("burst mark not placed at latency");

	a_start_gapless: assert property (@(posedge clk) disable iff (!rst_b)
		s_burst_open |-> bus.beat && bus.beat_index == 3'h0 ##1 left_reg == burst_beats(bus.bl8) - 4'h1)
		else $error("burst did not start on its edge");

	a_burst_len: assert property (@(posedge clk) disable iff (!rst_b)
		bus.beat && bus.last |-> bus.beat_index == (bus.bl8 ? 3'h7 : 3'h3))
		else $error("burst length wrong");
endmodule

// ==== ddr2_seq_device.sv ====
`timescale 1ns/10ps
// Purpose: device side command sequencing for a DDR2 style memory link
// Assumes: all link pins are asynchronous to clk and pass two flip-flops
// Notes: an eight word buffer stands in for the array, indexed by beat
module ddr2_seq_device #(
	parameter int EXIT_RD = ddr2_seq_pkg::EXIT_TO_READ_CLKS,
	parameter int EXIT_NR = ddr2_seq_pkg::EXIT_TO_NONREAD_CLKS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Link command pins
	input wire logic link_ck,
	input wire logic cke,
	input wire logic cs_b,
	input wire logic ras_b,
	input wire logic cas_b,
	input wire logic we_b,
	input wire logic [1:0] ba,
	input wire logic addr_ap,
	input wire logic termination_control,
	// Link data pins
	input wire logic [ddr2_seq_pkg::DATA_W-1:0] dq_in,
	output logic [ddr2_seq_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic dqs_out,
	output logic dqs_oe,
	// Configuration
	input wire logic [2:0] additive_latency,
	input wire logic [2:0] cas_latency,
	input wire logic burst_length_8,
	// Status
	output logic self_refresh,
	output logic power_down,
	output logic termination_on,
	output logic seq_error,
	output logic wr_beat,
	output logic [ddr2_seq_pkg::DATA_W-1:0] wr_word
);
	import ddr2_seq_pkg::*;

	logic [PIN_W-1:0] pin_s1_reg, pin_s2_reg;
	logic ck_prev_reg;
	logic rise, fall, cke_s, ap_s, term_s;
	logic [3:0] cmd_s;
	logic [1:0] ba_s;
	logic [DATA_W-1:0] dq_s;
	logic [3:0] read_latency, write_latency;

	// Two-stage sampler; only the second stage and later are decoded
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_reg <= PIN_RESET;
			pin_s2_reg <= PIN_RESET;
			ck_prev_reg <= 1'b0;
		end else begin
			pin_s1_reg <= {link_ck, cke, cs_b, ras_b, cas_b, we_b, ba, addr_ap,
				termination_control, dq_in};
			pin_s2_reg <= pin_s1_reg;
			ck_prev_reg <= pin_s2_reg[PIN_CK];
		end
	end

	assign rise = pin_s2_reg[PIN_CK] && !ck_prev_reg;
	assign fall = !pin_s2_reg[PIN_CK] && ck_prev_reg;
	assign cke_s = pin_s2_reg[PIN_CKE];
	assign cmd_s = pin_s2_reg[PIN_CMD_LSB +: 4];
	assign ba_s = pin_s2_reg[PIN_BA_LSB +: 2];
	assign ap_s = pin_s2_reg[PIN_AP];
	assign term_s = pin_s2_reg[PIN_TERM];
	assign dq_s = pin_s2_reg[DATA_W-1:0];
	assign read_latency = 4'(additive_latency) + 4'(cas_latency);
	assign write_latency = read_latency - 4'h1;

	mode_t mode_reg, mode_next;
	logic cke_prev_reg, cke_prev_next;
	logic [3:0] bank_open_reg, bank_open_next;
	logic [EXIT_W-1:0] exit_rd_reg, exit_rd_next, exit_nr_reg, exit_nr_next;
	logic error_reg, error_next;
	logic rd_go, wr_go;

	// Command decode, power state and protocol checking once per link rise; the termination check runs every cycle
	always_comb begin
		mode_next = mode_reg;
		cke_prev_next = cke_prev_reg;
		bank_open_next = bank_open_reg;
		exit_rd_next = exit_rd_reg;
		exit_nr_next = exit_nr_reg;
		error_next = error_reg;
		rd_go = 1'b0;
		wr_go = 1'b0;
		// Termination must stay off in self refresh and until reads are allowed
		if (term_s && (mode_reg == MODE_SELF_REFRESH || exit_rd_reg != '0)) begin
			error_next = 1'b1;
		end
		if (rise) begin
			cke_prev_next = cke_s;
			if (exit_rd_reg != '0) exit_rd_next = exit_rd_reg - 1'b1;
			if (exit_nr_reg != '0) exit_nr_next = exit_nr_reg - 1'b1;
			unique case (mode_reg)
				MODE_ACTIVE: begin
					if (cke_prev_reg && !cke_s && cmd_s == CMD_REFRESH) begin
						mode_next = MODE_SELF_REFRESH;
						if (bank_open_reg != 4'h0) error_next = 1'b1;
					end else if (cke_prev_reg && !cke_s) begin
						mode_next = MODE_POWER_DOWN;
					end else if (cke_s && cmd_s != CMD_NOP && !cmd_s[3]) begin
						if (cmd_s == CMD_READ && exit_rd_reg != '0) error_next = 1'b1;
						if (cmd_s != CMD_READ && exit_nr_reg != '0) error_next = 1'b1;
						if (cmd_s == CMD_ACTIVATE) bank_open_next[ba_s] = 1'b1;
						if (cmd_s == CMD_PRECHARGE) begin
							if (ap_s) bank_open_next = 4'h0;
							else bank_open_next[ba_s] = 1'b0;
						end
						if (cmd_s == CMD_READ || cmd_s == CMD_WRITE) begin
							// Bursts to an idle bank are flagged and dropped
							if (!bank_open_reg[ba_s]) error_next = 1'b1;
							else if (cmd_s == CMD_READ) rd_go = 1'b1;
							else wr_go = 1'b1;
							if (ap_s) bank_open_next[ba_s] = 1'b0;
						end
					end
				end
				MODE_SELF_REFRESH: begin
					if (cke_s) begin
						mode_next = MODE_ACTIVE;
						exit_rd_next = EXIT_W'(EXIT_RD);
						exit_nr_next = EXIT_W'(EXIT_NR);
					end
				end
				MODE_POWER_DOWN: begin
					if (cke_s) mode_next = MODE_ACTIVE;
				end
				default: mode_next = MODE_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= MODE_ACTIVE;
			cke_prev_reg <= 1'b0;
			bank_open_reg <= 4'h0;
			exit_rd_reg <= '0;
			exit_nr_reg <= '0;
			error_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			cke_prev_reg <= cke_prev_next;
			bank_open_reg <= bank_open_next;
			exit_rd_reg <= exit_rd_next;
			exit_nr_reg <= exit_nr_next;
			error_reg <= error_next;
		end
	end

	burst_if rd_if();
	burst_if wr_if();

	// Reads and writes each get their own latency pipe
	assign rd_if.rise = rise;
	assign rd_if.fall = fall;
	assign rd_if.cmd = rd_go;
	assign rd_if.bl8 = burst_length_8;
	assign rd_if.latency = read_latency;
	assign wr_if.rise = rise;
	assign wr_if.fall = fall;
	assign wr_if.cmd = wr_go;
	assign wr_if.bl8 = burst_length_8;
	assign wr_if.latency = write_latency;

	latency_pipe #(.MAX_LAT(MAX_LATENCY)) rd_pipe (.clk(clk), .rst_b(rst_b), .bus(rd_if.pipe));
	latency_pipe #(.MAX_LAT(MAX_LATENCY)) wr_pipe (.clk(clk), .rst_b(rst_b), .bus(wr_if.pipe));

	logic [DATA_W-1:0] buf_reg [8];
	logic [DATA_W-1:0] buf_next [8];
	logic [DATA_W-1:0] dq_out_reg, dq_out_next, wr_word_reg, wr_word_next;
	logic dq_oe_reg, dq_oe_next, dqs_reg, dqs_next, wr_beat_reg, wr_beat_next;

	// Data path: writes land by beat index, reads replay from the same slots
	always_comb begin
		buf_next = buf_reg;
		dq_out_next = dq_out_reg;
		wr_word_next = wr_word_reg;
		wr_beat_next = 1'b0;
		dqs_next = dqs_reg;
		dq_oe_next = rd_if.beat || (dq_oe_reg && rd_if.active);
		if (wr_if.beat) begin
			buf_next[wr_if.beat_index] = dq_s;
			wr_word_next = dq_s;
			wr_beat_next = 1'b1;
		end
		if (rd_if.beat) begin
			dq_out_next = buf_reg[rd_if.beat_index];
			dqs_next = rise;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 8; i++) buf_reg[i] <= '0;
			dq_out_reg <= '0;
			wr_word_reg <= '0;
			wr_beat_reg <= 1'b0;
			dq_oe_reg <= 1'b0;
			dqs_reg <= 1'b0;
		end else begin
			buf_reg <= buf_next;
			dq_out_reg <= dq_out_next;
			wr_word_reg <= wr_word_next;
			wr_beat_reg <= wr_beat_next;
			dq_oe_reg <= dq_oe_next;
			dqs_reg <= dqs_next;
		end
	end

	assign dq_out = dq_out_reg;
	assign dq_oe = dq_oe_reg;
	assign dqs_out = dqs_reg;
	assign dqs_oe = dq_oe_reg;
	assign wr_beat = wr_beat_reg;
	assign wr_word = wr_word_reg;
	assign self_refresh = mode_reg == MODE_SELF_REFRESH;
	assign power_down = mode_reg == MODE_POWER_DOWN;
	// Termination is honoured only while awake, so a late deassert cannot load the bus
	assign termination_on = term_s && mode_reg == MODE_ACTIVE;
	assign seq_error = error_reg;

	// Checks the write pipe itself, so a wrong latency feed shows up here
	a_wr_latency: assert property (@(posedge clk) disable iff (!rst_b)
		wr_go && read_latency > 4'h1
		|=> wr_pipe.sched_reg[4'(additive_latency) + 4'(cas_latency) - 4'h2])
		else $error("write latency not read latency minus one");

	a_early_read: assert property (@(posedge clk) disable iff (!rst_b)
		rise && mode_reg == MODE_ACTIVE && cke_prev_reg && cke_s && cmd_s == CMD_READ
		&& exit_rd_reg != '0 |=> seq_error)
		else $error("read inside exit delay not flagged");

	a_sr_banks: assert property (@(posedge clk) disable iff (!rst_b)
		rise && mode_reg == MODE_ACTIVE && cke_prev_reg && !cke_s && cmd_s == CMD_REFRESH
		&& bank_open_reg != 4'h0 |=> seq_error && self_refresh)
		else $error("self refresh with open bank not flagged");

	a_term_sr: assert property (@(posedge clk) disable iff (!rst_b)
		term_s && (self_refresh || exit_rd_reg != '0) |=> seq_error)
		else $error("termination on in self refresh");

	a_closed_bank: assert property (@(posedge clk) disable iff (!rst_b)
		rd_go |-> bank_open_reg[ba_s] ##1 rd_if.active)
		else $error("read to idle bank scheduled");
endmodule

// ==== ddr2_ctrl_model.sv ====
`timescale 1ns/10ps
// Purpose: controller model driving link clock, commands and write data
// Assumes: command pins change on link falls and stand through the next rise
// Notes: idle data lines toggle so a stale word never looks valid
module ddr2_ctrl_model (
	// Link clock and command pins
	output logic link_ck,
	output logic cke,
	output logic [3:0] cmd_pins,
	output logic [1:0] ba,
	output logic addr_ap,
	output logic termination_control,
	// Write data pins
	output logic [ddr2_seq_pkg::DATA_W-1:0] dq_in
);
	import ddr2_seq_pkg::*;
	int rises;
	int nxt;
	time t_rise;
	logic [DATA_W-1:0] wdata [int];
	// Fixed rate link clock, so no frequency step ever happens in power down
	initial begin
		{cke, cmd_pins, ba, addr_ap, termination_control} = {1'b0, CMD_NOP, 4'h0};
		dq_in = '0;
		rises = 0;
		link_ck = 1'b0;
		#137;
		forever #400 link_ck = ~link_ck;
	end
	// Count rises; half a phase later set up data for the next edge
	always @(link_ck) begin
		if (link_ck === 1'b1) begin
			rises++;
			t_rise = $time;
		end
		nxt = 2 * rises + (link_ck ? 1 : 2);
		#200;
		dq_in = wdata.exists(nxt) ? wdata[nxt] : ~dq_in;
	end
	// Command on the next rise; reports its rise index and time
	task automatic cmd(input logic [3:0] code, input logic [1:0] bank, input logic ap,
		input logic ck, output int r, output time t);
		@(negedge link_ck);
		{cke, cmd_pins, ba, addr_ap} = {ck, code, bank, ap};
		@(posedge link_ck);
		#1;
		r = rises;
		t = t_rise;
	endtask
	// NOP from the next fall, so the next command lands slot rises later
	task automatic idle(input int slot);
		@(negedge link_ck);
		cmd_pins = CMD_NOP;
		{ba, addr_ap} = 3'($urandom); // NOP ignores bank and auto-precharge
		repeat (slot - 1) @(posedge link_ck);
	endtask
	// Termination changes on a fall, apart from commands
	task automatic set_term(input logic v);
		@(negedge link_ck);
		termination_control = v;
	endtask
endmodule

// ==== tb_ddr2_command_sequencing_rules.sv ====
`timescale 1ns/10ps
// Purpose: self-checking bench for the DDR2 device sequencing block
// Assumes: 800 ns link clock; a monitor scores beats from note queues
// Notes: exit windows cut to 8 and 3 link rises to keep the run short
module tb_ddr2_command_sequencing_rules;
	import ddr2_seq_pkg::*;
	typedef struct {logic [15:0] w; time t;} note_t;
	logic clk, rst_b, link_ck, cke, cs_b, ras_b, cas_b, we_b, addr_ap, termination_control;
	logic dq_oe, dqs_out, dqs_oe, self_refresh, power_down, termination_on, seq_error, wr_beat;
	logic burst_length_8, prev_dqs;
	logic [1:0] ba;
	logic [2:0] additive_latency, cas_latency;
	logic [3:0] cmd_pins;
	logic [15:0] dq_in, dq_out, wr_word;
	logic [15:0] mem [8];
	note_t rq[$], wq[$], nt;
	int n_errors = 0, num_checks = 0, cyc = 0;
	assign {cs_b, ras_b, cas_b, we_b} = cmd_pins;
	ddr2_ctrl_model u_ctrl (.link_ck(link_ck), .cke(cke), .cmd_pins(cmd_pins), .ba(ba),
		.addr_ap(addr_ap), .termination_control(termination_control), .dq_in(dq_in));
	ddr2_seq_device #(.EXIT_RD(8), .EXIT_NR(3)) DUT (.clk(clk), .rst_b(rst_b),
		.link_ck(link_ck), .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
		.ba(ba), .addr_ap(addr_ap), .termination_control(termination_control), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
		.additive_latency(additive_latency), .cas_latency(cas_latency),
		.burst_length_8(burst_length_8), .self_refresh(self_refresh), .power_down(power_down),
		.termination_on(termination_on), .seq_error(seq_error), .wr_beat(wr_beat),
		.wr_word(wr_word));
	// System clock, 100 ns
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Hang guard, far above the planned run of a few thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		if (n_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Read beat = strobe change while driving; a beat with no note fails
	always @(posedge clk) begin
		#1;
		if (dq_oe === 1'b1 && dqs_out !== prev_dqs) begin
			if (rq.size() == 0) nt = '{~dq_out, 0};
			else nt = rq.pop_front();
			chk(dq_out, nt.w);
			chk(16'(($time - nt.t) inside {[150:550]}), 16'h0001);
		end
		if (wr_beat === 1'b1) begin
			if (wq.size() == 0) nt = '{~wr_word, 0};
			else nt = wq.pop_front();
			chk(wr_word, nt.w);
			chk(16'(($time - nt.t) inside {[150:550]}), 16'h0001);
		end
		prev_dqs = dqs_out;
	end
	task automatic reset_dut();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic issue(input logic [3:0] code, input logic [1:0] b, input logic ap,
		input logic ck, input int slot);
		int r;
		time t;
		u_ctrl.cmd(code, b, ap, ck, r, t);
		u_ctrl.idle(slot);
	endtask
	// Seamless writes to a random bank pair, reads back, then a trailing write
	task automatic traffic(input logic [2:0] al, input logic [2:0] cl, input logic b8);
		int r, n;
		time t;
		logic [1:0] b;
		bit wr;
		n = b8 ? 8 : 4;
		b = 2'($urandom);
		@(posedge clk);
		additive_latency <= al;
		cas_latency <= cl;
		burst_length_8 <= b8;
		// Banks closed by auto-precharge last round reopen only after its long idle
		issue(CMD_ACTIVATE, b, 1'b0, 1'b1, 2);
		issue(CMD_ACTIVATE, b ^ 2'h1, 1'b0, 1'b1, 2);
		// Last read and the trailing write close their banks by auto-precharge
		for (int k = 0; k < 5; k++) begin
			wr = k < 2 || k == 4;
			u_ctrl.cmd(wr ? CMD_WRITE : CMD_READ, b ^ 2'(k & 1), k > 2, 1'b1, r, t);
			for (int j = 0; j < n; j++) begin
				if (wr) begin
					mem[j] = 16'($urandom);
					u_ctrl.wdata[2 * (r + al + cl - 1) + j] = mem[j];
					wq.push_back('{mem[j], t + (al + cl - 1) * 800 + j * 400});
				end else begin
					rq.push_back('{mem[j], t + (al + cl) * 800 + j * 400});
				end
			end
			u_ctrl.idle(n / 2);
		end
		u_ctrl.idle(16);
		chk(16'(rq.size() + wq.size()), 16'h0000);
	endtask
	initial begin
		int r;
		time t;
		rst_b = 1'b0;
		additive_latency = 3'h2;
		cas_latency = 3'h3;
		burst_length_8 = 1'b0;
		prev_dqs = 1'b0;
		void'($urandom(32'hDB70ED49));
		reset_dut();
		chk({dq_oe, dqs_oe, self_refresh, power_down, seq_error, wr_beat}, 16'h0000);
		issue(CMD_NOP, 2'h0, 1'b0, 1'b1, 4);
		// A deselected read to an idle bank must be ignored
		issue(4'hD, 2'h3, 1'b0, 1'b1, 2);
		chk(seq_error, 16'h0000);
		traffic(3'h2, 3'h3, 1'b0);
		repeat (3) traffic(3'($urandom_range(3)), 3'($urandom_range(5, 2)), 1'($urandom));
		// Self refresh round trip with termination, then power down
		u_ctrl.set_term(1'b1);
		issue(CMD_PRECHARGE, 2'h0, 1'b1, 1'b1, 4);
		chk({termination_on, seq_error}, 16'h0002);
		u_ctrl.set_term(1'b0);
		issue(CMD_NOP, 2'h0, 1'b0, 1'b1, 2);
		issue(CMD_REFRESH, 2'h0, 1'b0, 1'b0, 4);
		chk({self_refresh, termination_on}, 16'h0002);
		issue(CMD_NOP, 2'h0, 1'b0, 1'b1, 10);
		u_ctrl.set_term(1'b1);
		issue(CMD_NOP, 2'h0, 1'b0, 1'b0, 4);
		chk({self_refresh, power_down, seq_error}, 16'h0002);
		issue(CMD_NOP, 2'h0, 1'b0, 1'b1, 4);
		chk({power_down, termination_on}, 16'h0001);
		u_ctrl.set_term(1'b0);
		// Refused cases, each from a clean reset since the flag is sticky
		for (int k = 0; k < 5; k++) begin
			reset_dut();
			issue(CMD_NOP, 2'h0, 1'b0, 1'b1, 4);
			case (k)
				0: issue(CMD_READ, 2'h3, 1'b0, 1'b1, 8);
				1: begin
					issue(CMD_REFRESH, 2'h0, 1'b0, 1'b0, 4);
					issue(CMD_NOP, 2'h0, 1'b0, 1'b1, 2);
					issue(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1, 2);
				end
				2: begin
					issue(CMD_REFRESH, 2'h0, 1'b0, 1'b0, 2);
					u_ctrl.set_term(1'b1);
					issue(CMD_NOP, 2'h0, 1'b0, 1'b0, 4);
					u_ctrl.set_term(1'b0);
				end
				4: begin
					issue(CMD_REFRESH, 2'h0, 1'b0, 1'b0, 2);
					issue(CMD_NOP, 2'h0, 1'b0, 1'b1, 4);
					issue(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1, 2);
					// The early read still runs, so its beats of cleared slots are noted
					u_ctrl.cmd(CMD_READ, 2'h0, 1'b0, 1'b1, r, t);
					for (int j = 0; j < (burst_length_8 ? 8 : 4); j++) begin
						rq.push_back('{16'h0000, t + (additive_latency + cas_latency) * 800
							+ j * 400});
					end
					u_ctrl.idle(16);
				end
				default: begin
					issue(CMD_ACTIVATE, 2'h2, 1'b0, 1'b1, 2);
					issue(CMD_REFRESH, 2'h0, 1'b0, 1'b0, 4);
				end
			endcase
			chk(seq_error, 16'h0001);
		end
		end_sim();
	end
endmodule
